// ==== acbs_pkg.sv ====
package acbs_pkg;
   // ==========================================
   // register map and fields
   localparam logic [3:0] ACBS_CFG_OFFSET = 4'hb;
   localparam logic [3:0] ACBS_CT0_OFFSET = 4'hc;
   localparam logic [3:0] ACBS_CTCFG_OFFSET = 4'hf;
   localparam logic [3:0] ACBS_IDX_LO_OFFSET = 4'hc;
   localparam logic [3:0] ACBS_IDX_HI_OFFSET = 4'hd;
   localparam int ACBS_KEY_MSB = 7;
   localparam int ACBS_KEY_LSB = 4;
   localparam int ACBS_BANK_POS = 7;
   localparam int ACBS_TRIG_POS = 3;
   localparam int ACBS_POL_POS = 2;
   localparam int ACBS_GAIN_MSB = 1;
   localparam int ACBS_GAIN_LSB = 0;
   localparam logic [1:0] ACBS_GAIN_RESET = 2'h0;
   localparam logic ACBS_BANK_RESET = 1'h0;
   // ==========================================
   // key nibbles
   localparam logic [3:0] ACBS_KEY_ON_0 = 4'hf;
   localparam logic [3:0] ACBS_KEY_ON_1 = 4'h5;
   localparam logic [3:0] ACBS_KEY_ON_2 = 4'hd;
   localparam logic [3:0] ACBS_KEY_OFF_0 = 4'h3;
   localparam logic [3:0] ACBS_KEY_OFF_1 = 4'hb;
   localparam logic [3:0] ACBS_KEY_OFF_2 = 4'ha;
   // ==========================================
   // types
   typedef enum logic [4:0] {
      ACBS_IDLE = 5'h01,
      ACBS_ON1 = 5'h02,
      ACBS_ON2 = 5'h04,
      ACBS_OFF1 = 5'h08,
      ACBS_OFF2 = 5'h10
   } acbs_key_state_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } acbs_bus_req_t;
   typedef struct packed {
      logic ctBankSel;
      logic idxBankSel;
      logic [3:0] addr;
   } acbs_route_t;
endpackage

// ==== acbs_key_detect.sv ====
`timescale 1ns/100ps
module acbs_key_detect (
   input wire logic clk,
   input wire logic nrst,
   input wire logic enable,
   input wire logic keyWrite,
   input wire logic [3:0] bankKeyNibble,
   output logic bankStatus
);
   import acbs_pkg::*;
   acbs_key_state_t state, next_state;
   logic next_bankStatus;

   // ==========================================
   // key sequence matcher
   always_comb begin
      next_state = state;
      next_bankStatus = bankStatus;
      if (!enable) begin
         next_state = ACBS_IDLE;
         next_bankStatus = ACBS_BANK_RESET;
      end else if (keyWrite) begin
         // restart on a first key so F,F,5,D still matches
         next_state = ACBS_IDLE;
         if (bankKeyNibble == ACBS_KEY_ON_0) begin
            next_state = ACBS_ON1;
         end else if (bankKeyNibble == ACBS_KEY_OFF_0) begin
            next_state = ACBS_OFF1;
         end
         case (state)
            ACBS_ON1: begin
               if (bankKeyNibble == ACBS_KEY_ON_1) begin
                  next_state = ACBS_ON2;
               end
            end
            ACBS_ON2: begin
               if (bankKeyNibble == ACBS_KEY_ON_2) begin
                  next_bankStatus = 1'b1;
                  next_state = ACBS_IDLE;
               end
            end
            ACBS_OFF1: begin
               if (bankKeyNibble == ACBS_KEY_OFF_1) begin
                  next_state = ACBS_OFF2;
               end
            end
            ACBS_OFF2: begin
               if (bankKeyNibble == ACBS_KEY_OFF_2) begin
                  next_bankStatus = 1'b0;
                  next_state = ACBS_IDLE;
               end
            end
            default: begin
            end
         endcase
      end
      // any other sequence leaves the bank as it was
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= ACBS_IDLE;
         bankStatus <= ACBS_BANK_RESET;
      end else begin
         state <= next_state;
         bankStatus <= next_bankStatus;
      end
   end
endmodule

// ==== acbs_gain_reg.sv ====
`timescale 1ns/100ps
module acbs_gain_reg (
   input wire logic clk,
   input wire logic nrst,
   input wire logic load,
   input wire logic [1:0] gainIn,
   output logic [1:0] gain,
   output logic [3:0] gainFactor
);
   import acbs_pkg::*;
   logic [1:0] next_gain;

   // ==========================================
   // gain store
   always_comb begin
      next_gain = gain;
      if (load) begin
         next_gain = gainIn;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gain <= ACBS_GAIN_RESET;
      end else begin
         gain <= next_gain;
      end
   end

   // one shared factor for every channel: 1, 2, 4, 8
   assign gainFactor = 4'h1 << gain;
endmodule

// ==== acbs_config_bank.sv ====
`timescale 1ns/100ps
// Contract
// - write takes key from bits 7:4, gain from 1:0, ignores 3:2
// - read gives bank 7, trigger 3, polarity 2, gain 1:0
// - bank bit 0 counter bank, 1 indexed bank; enhanced mode only
// - reset always selects the counter/timer bank
// - writes with keys F, 5, D select the indexed bank
// - writes with keys 3, B, A return to counter bank
// - any other write sequence leaves the bank unchanged
// - two-bit gain is read/write, resets to 00, codes x1..x8
// - gain applies to all channels; read returns gain in effect
// - polarity bit read-only from jumper: 0 bipolar, 1 unipolar
// - trigger bit mirrors trigger-active status flag
// - samples span signed 16-bit range for any gain and polarity
// - bank 0 routes 0xC-0xF to counters; bank 1 routes 12,13 index
module acbs_config_bank (
   input wire logic clk,
   input wire logic nrst,
   input wire acbs_pkg::acbs_bus_req_t busReq,
   output logic [7:0] rdata,
   output logic rdataValid,
   input wire logic enhancedMode,
   input wire logic polarityJumper,
   input wire logic triggerStateStatus,
   input wire logic signed [15:0] rawSample,
   output logic signed [15:0] sample,
   output logic bankStatus,
   output logic [1:0] gain,
   output logic [3:0] gainFactor,
   output acbs_pkg::acbs_route_t route
);
   import acbs_pkg::*;
   logic cfgHit;
   logic cfgWrite;
   logic [7:0] next_rdata;
   logic next_rdataValid;
   logic signed [15:0] next_sample;
   logic inputPolarity;
   logic triggerActiveFlag;

   // ==========================================
   // decode
   always_comb begin
      cfgHit = 1'b0;
      if (busReq.addr == ACBS_CFG_OFFSET) begin
         cfgHit = 1'b1;
      end
   end
   assign cfgWrite = busReq.wr && cfgHit;

   // ==========================================
   // bank key and gain
   acbs_key_detect u_key (
      .clk(clk),
      .nrst(nrst),
      .enable(enhancedMode),
      .keyWrite(cfgWrite),
      .bankKeyNibble(busReq.wdata[ACBS_KEY_MSB:ACBS_KEY_LSB]),
      .bankStatus(bankStatus)
   );

   acbs_gain_reg u_gain (
      .clk(clk),
      .nrst(nrst),
      .load(cfgWrite),
      // bits 3:2 of the write are dropped here
      .gainIn(busReq.wdata[ACBS_GAIN_MSB:ACBS_GAIN_LSB]),
      .gain(gain),
      .gainFactor(gainFactor)
   );

   assign inputPolarity = polarityJumper;
   assign triggerActiveFlag = triggerStateStatus;

   // ==========================================
   // read path, registered one cycle after rd
   always_comb begin
      next_rdata = 8'h00;
      next_rdataValid = 1'b0;
      if (busReq.rd && cfgHit) begin
         next_rdataValid = 1'b1;
         next_rdata[ACBS_BANK_POS] = bankStatus;
         next_rdata[ACBS_TRIG_POS] = triggerActiveFlag;
         next_rdata[ACBS_POL_POS] = inputPolarity;
         next_rdata[ACBS_GAIN_MSB:ACBS_GAIN_LSB] = gain;
      end
   end

   // ==========================================
   // sample pass-through; full range kept at every gain
   always_comb begin
      next_sample = rawSample;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= 8'h00;
         rdataValid <= 1'b0;
         sample <= 16'sh0000;
      end else begin
         rdata <= next_rdata;
         rdataValid <= next_rdataValid;
         sample <= next_sample;
      end
   end

   // ==========================================
   // bank routing of the upper offsets
   always_comb begin
      route.addr = busReq.addr;
      route.ctBankSel = 1'b0;
      route.idxBankSel = 1'b0;
      if (!bankStatus && busReq.addr >= ACBS_CT0_OFFSET) begin
         route.ctBankSel = 1'b1;
      end else if (bankStatus && (busReq.addr == ACBS_IDX_LO_OFFSET ||
            busReq.addr == ACBS_IDX_HI_OFFSET)) begin
         route.idxBankSel = 1'b1;
      end
   end
endmodule

// ==== acbs_config_bank_checker.sv ====
`timescale 1ns/100ps
module acbs_config_bank_checker (
   input wire logic clk,
   input wire logic nrst,
   input wire acbs_pkg::acbs_bus_req_t busReq,
   input wire logic [7:0] rdata,
   input wire logic rdataValid,
   input wire logic enhancedMode,
   input wire logic polarityJumper,
   input wire logic triggerStateStatus,
   input wire logic signed [15:0] rawSample,
   input wire logic signed [15:0] sample,
   input wire logic bankStatus,
   input wire logic [1:0] gain,
   input wire logic [3:0] gainFactor,
   input wire acbs_pkg::acbs_route_t route
);
   import acbs_pkg::*;
   logic cfgWr;
   logic cfgRd;
   assign cfgWr = busReq.wr && busReq.addr == ACBS_CFG_OFFSET;
   assign cfgRd = busReq.rd && busReq.addr == ACBS_CFG_OFFSET;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // ======
   // read side
   chk_read_strobe: assert property (
      $past(nrst) |-> rdataValid == $past(cfgRd))
      else $error("read strobe off");
   chk_read_data: assert property (
      cfgRd |=> rdata == {$past(bankStatus), 3'h0,
      $past(triggerStateStatus), $past(polarityJumper), $past(gain)})
      else $error("read data wrong");
   // ======
   // gain, bank, sample and routing
   chk_gain_load: assert property (
      cfgWr |=> gain == $past(busReq.wdata[1:0]))
      else $error("gain not loaded");
   chk_gain_hold: assert property (
      !cfgWr |=> $stable(gain))
      else $error("gain moved");
   chk_gain_factor: assert property (
      gainFactor == 4'h1 << gain)
      else $error("gain factor wrong");
   chk_bank_mode: assert property (
      !enhancedMode |=> !bankStatus)
      else $error("bank set outside mode");
   chk_bank_set: assert property (
      $rose(bankStatus) |-> $past(cfgWr) &&
      $past(busReq.wdata[7:4]) == ACBS_KEY_ON_2)
      else $error("bank set without key");
   // the mode may already be back on when the drop shows
   chk_bank_clear: assert property (
      $fell(bankStatus) |-> !$past(enhancedMode) ||
      $past(cfgWr) && $past(busReq.wdata[7:4]) == ACBS_KEY_OFF_2)
      else $error("bank cleared without key");
   chk_sample_pass: assert property (
      $past(nrst) |-> sample == $past(rawSample))
      else $error("sample not passed");
   chk_route_sel: assert property (
      route.ctBankSel == (!bankStatus && busReq.addr >= ACBS_CT0_OFFSET))
      else $error("route select wrong");
   chk_route_idx: assert property (
      route.idxBankSel == (bankStatus &&
      (busReq.addr == ACBS_IDX_LO_OFFSET ||
      busReq.addr == ACBS_IDX_HI_OFFSET)) && route.addr == busReq.addr)
      else $error("index route wrong");
endmodule

// ==== acbs_host_model.sv ====
`timescale 1ns/100ps
module acbs_host_model (
   input wire logic clk,
   input wire logic [7:0] rdata,
   input wire logic rdataValid,
   output acbs_pkg::acbs_bus_req_t busReq
);
   import acbs_pkg::*;
   initial busReq = '0;
   // one strobe per access; an idle edge always follows it
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      busReq <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      busReq <= '0;
   endtask
   task rd(output logic [8:0] v);
      @(posedge clk);
      busReq <= '{1'b0, 1'b1, ACBS_CFG_OFFSET, 8'h0};
      @(posedge clk);
      busReq <= '0;
      #1 v = {rdataValid, rdata};
   endtask
   // low nibble carries the gain so a switch keeps it
   task key(input logic [3:0] a, input logic [3:0] n, input logic [1:0] g);
      wr(a, {n, 2'h0, g});
   endtask
   // read the bank bit first; key writes only when a change is due
   task bank(input logic b, input logic [1:0] g);
      logic [8:0] s;
      rd(s);
      if (s[7] != b) begin
         key(ACBS_CFG_OFFSET, b ? ACBS_KEY_ON_0 : ACBS_KEY_OFF_0, g);
         key(ACBS_CFG_OFFSET, b ? ACBS_KEY_ON_1 : ACBS_KEY_OFF_1, g);
         key(ACBS_CFG_OFFSET, b ? ACBS_KEY_ON_2 : ACBS_KEY_OFF_2, g);
      end
   endtask
endmodule

// ==== test_adc_config_bank_select.sv ====
`timescale 1ns/100ps
module test_adc_config_bank_select;
   import acbs_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic enhancedMode = 1'b1;
   logic polarityJumper = 1'b0;
   logic triggerStateStatus = 1'b0;
   logic signed [15:0] rawSample = '0;
   acbs_bus_req_t busReq;
   logic [7:0] rdata;
   logic rdataValid;
   logic signed [15:0] sample;
   logic bankStatus;
   logic [1:0] gain;
   logic [3:0] gainFactor;
   acbs_route_t route;
   logic [8:0] v;
   logic [1:0] g = 2'h0;
   logic [11:0] seqs [10] = '{12'hff5, 12'hd3b, 12'ha5d, 12'hf5d,
      12'h3b3, 12'hba0, 12'hf5d, 12'h000, 12'hf5d, 12'h5d3};
   logic [9:0] ens = 10'h27f;
   logic [9:0] bks = 10'h05a;
   int fails = 0;
   int comparisons = 0;
   always #5 clk = ~clk;
   acbs_config_bank i_dut (.clk, .nrst, .busReq, .rdata, .rdataValid,
      .enhancedMode, .polarityJumper, .triggerStateStatus, .rawSample,
      .sample, .bankStatus, .gain, .gainFactor, .route);
   acbs_host_model i_host (.clk, .rdata, .rdataValid, .busReq);
   task chk(input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e) begin
         fails++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   function logic [8:0] expRd(input logic b);
      return {1'b1, b, 3'h0, triggerStateStatus, polarityJumper, g};
   endfunction
   task test_done;
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #100000;
      fails++;
      test_done;
   end
   initial begin
      void'($urandom(64811));
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      i_host.rd(v);
      chk(v, expRd(1'b0));
      for (int i = 0; i < 10; i++) begin
         @(posedge clk);
         enhancedMode <= ens[i];
         for (int j = 2; j >= 0; j--)
            i_host.key(ACBS_CFG_OFFSET, seqs[i][j*4+:4], g);
         i_host.rd(v);
         chk(v, expRd(bks[i]));
      end
      // a write elsewhere must not break the key run
      i_host.key(ACBS_CFG_OFFSET, 4'hf, g);
      i_host.key(ACBS_CFG_OFFSET, 4'h5, g);
      i_host.key(ACBS_CT0_OFFSET, 4'h3, g);
      i_host.key(ACBS_CFG_OFFSET, 4'hd, g);
      i_host.rd(v);
      chk(v, expRd(1'b1));
      for (int i = 0; i < 30; i++) begin
         @(posedge clk);
         triggerStateStatus <= 1'($urandom);
         polarityJumper <= 1'($urandom);
         rawSample <= i == 0 ? 16'h8000 : i == 1 ? 16'h7fff : 16'($urandom);
         g = 2'($urandom);
         i_host.wr(4'($urandom % 2) ? ACBS_CFG_OFFSET : ACBS_IDX_HI_OFFSET,
            {4'($urandom % 3), 2'($urandom), g});
         i_host.wr(ACBS_CFG_OFFSET, {4'($urandom % 3), 2'($urandom), g});
         i_host.rd(v);
         chk(v, expRd(1'b1));
         chk(16'(gainFactor), 16'(4'h1 << g));
         chk(sample, rawSample);
      end
      i_host.bank(1'b0, g);
      i_host.rd(v);
      chk(v, expRd(1'b0));
      // a needless switch would write and break this key run
      i_host.key(ACBS_CFG_OFFSET, ACBS_KEY_ON_0, g);
      i_host.key(ACBS_CFG_OFFSET, ACBS_KEY_ON_1, g);
      i_host.bank(1'b0, g);
      i_host.key(ACBS_CFG_OFFSET, ACBS_KEY_ON_2, g);
      i_host.rd(v);
      chk(v, expRd(1'b1));
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      g = 2'h0;
      i_host.rd(v);
      chk(v, expRd(1'b0));
      test_done;
   end
endmodule
bind acbs_config_bank acbs_config_bank_checker i_chk (.clk, .nrst, .busReq,
   .rdata, .rdataValid, .enhancedMode, .polarityJumper, .triggerStateStatus,
   .rawSample, .sample, .bankStatus, .gain, .gainFactor, .route);
